/* File: rtl/global_shutter_exposure_sequencer.sv */
// Global-shutter exposure sequencer: drain, expose, transfer, two readouts
//
// Contract
// - Drain high before each exposure empties every pixel.
// - All pixels start together and collect for the whole exposure.
// - At exposure end all pixels move charge to readout at once.
// - Each acquisition reads a reference frame and a signal frame.
// - A host start launches the sequence; its pulse stays internal.
// - Exposure-active is high exactly during the common exposure.
// - Per-row, all-rows and any-row flags equal exposure-active.
// - In triggered modes ready is high only while waiting for a trigger.
// - Drain high keeps pixels empty; drain low lets them integrate.
// - The falling edge of the drain pulse starts each exposure.
// - Charge-move ends exposure and transfers charge while high.
// - A readout-phase flag marks reference and signal readouts.
// - A minimum gap separates reference end and signal start.
// - One row period is 2624 clock cycles.
// - A frame is the row count each sensor half reads for the region.
// - Internal mode waits for full readout before a new exposure.
module global_shutter_exposure_sequencer
  import gs_seq_pkg::*;
#(
  parameter int unsigned ROW_LEN   = ROW_CYCLES,
  parameter int unsigned MOVE_LEN  = CHARGE_MOVE_CYCLES,
  parameter int unsigned MIN_GAP   = INTERFRAME_ROWS
) (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire logic                   acq_start,
  input  wire logic                   acq_stop,
  input  wire logic [1:0]             trig_mode,
  input  wire logic                   sw_trig,
  input  wire logic                   ext_trig_in,
  input  wire logic [EXP_W-1:0]       exposure_rows,
  input  wire logic [ROI_W-1:0]       frame_rows,
  input  wire logic [GAP_W-1:0]       gap_rows,
  input  wire logic [FRAME_CNT_W-1:0] frame_total,
  output logic                        pixel_drain_out,
  output logic                        charge_move_out,
  output logic                        exposure_active_out,
  output logic                        row_n_exposing_out,
  output logic                        all_rows_exposing_out,
  output logic                        any_row_exposing_out,
  output logic                        trigger_ready_out,
  output logic                        readout_phase_out,
  output logic                        ref_frame_out,
  output logic                        signal_frame_out,
  output logic                        busy_out
);

  // ==========================================================================
  // Row timer
  // ==========================================================================
  row_tick_if rt ();

  row_timer #(
    .ROW_LEN (ROW_LEN)
  ) u_row_timer (
    .mclk (mclk),
    .rstn (rstn),
    .rt   (rt.timer)
  );

  // ==========================================================================
  // External trigger synchroniser and edge detect
  // ==========================================================================
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_prev_q;
  logic ext_s1_d;
  logic ext_s2_d;
  logic ext_prev_d;
  logic ext_rise;

  always_comb begin
    ext_s1_d   = ext_trig_in;
    ext_s2_d   = ext_s1_q;
    ext_prev_d = ext_s2_q;
    ext_rise   = ext_s2_q & ~ext_prev_q;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_s1_q   <= 1'b0;
      ext_s2_q   <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      ext_s1_q   <= ext_s1_d;
      ext_s2_q   <= ext_s2_d;
      ext_prev_q <= ext_prev_d;
    end
  end

  // ==========================================================================
  // Sequencer state
  // ==========================================================================
  seq_state_t             state_q;
  seq_state_t             state_d;
  trig_mode_t             mode_q;
  trig_mode_t             mode_d;
  logic [EXP_W-1:0]       rows_q;
  logic [EXP_W-1:0]       rows_d;
  logic [CYC_W-1:0]       move_q;
  logic [CYC_W-1:0]       move_d;
  logic [FRAME_CNT_W-1:0] frames_q;
  logic [FRAME_CNT_W-1:0] frames_d;

  logic [EXP_W-1:0]       rows_nx;
  logic [EXP_W-1:0]       target;
  logic [EXP_W-1:0]       exp_len;
  logic [EXP_W-1:0]       frame_len;
  logic [EXP_W-1:0]       gap_len;
  logic                   row_done;
  logic                   trig_exposure_active_out;
  logic                   last_frame;
  seq_state_t             after_frame;

  // Targets held as row counts; zero exposure clamps to one row, zero frame to a full frame
  always_comb begin
    exp_len   = (exposure_rows == '0) ? EXP_W'(1) : exposure_rows;
    // Frame length in rows per sensor half
    frame_len = (frame_rows == '0) ? EXP_W'(FULL_FRAME_ROWS)
                                   : EXP_W'(frame_rows);
    // Gap never shorter than the interframe minimum
    gap_len   = (EXP_W'(gap_rows) < EXP_W'(MIN_GAP)) ? EXP_W'(MIN_GAP)
                                                       : EXP_W'(gap_rows);
  end

  always_comb begin
    case (state_q)
      ST_DRAIN:    target = EXP_W'(DRAIN_ROWS);
      ST_EXPOSE:   target = exp_len;
      ST_READ_REF: target = frame_len;
      ST_GAP:      target = gap_len;
      ST_READ_SIG: target = frame_len;
      default:     target = EXP_W'(1);
    endcase
  end

  always_comb begin
    rows_nx     = rows_q + 1'b1;
    row_done    = rt.row_tick & (rows_nx >= target);
    // Triggers count only while ready is shown; others are dropped
    trig_exposure_active_out   = (state_q == ST_WAIT_TRIG) &&
                  (((mode_q == TRIG_EXTERNAL) && ext_rise) ||
                   ((mode_q == TRIG_SOFTWARE) && sw_trig));
    last_frame  = (frames_q == FRAME_CNT_W'(1));
    // Internal mode only re-drains after the signal readout ends
    after_frame = (mode_q == TRIG_INTERNAL) ? ST_DRAIN : ST_WAIT_TRIG;
  end

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    state_d    = state_q;
    mode_d     = mode_q;
    rows_d     = rows_q;
    move_d     = move_q;
    frames_d   = frames_q;
    rt.restart = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (acq_start) begin
          mode_d     = (trig_mode == 2'(TRIG_EXTERNAL)) ? TRIG_EXTERNAL :
                       (trig_mode == 2'(TRIG_SOFTWARE)) ? TRIG_SOFTWARE :
                                                          TRIG_INTERNAL;
          frames_d   = frame_total;
          rows_d     = '0;
          rt.restart = 1'b1;
          state_d    = (trig_mode == 2'(TRIG_EXTERNAL) ||
                        trig_mode == 2'(TRIG_SOFTWARE)) ? ST_WAIT_TRIG
                                                        : ST_DRAIN;
        end
      end
      ST_WAIT_TRIG: begin
        if (trig_exposure_active_out) begin
          rows_d     = '0;
          rt.restart = 1'b1;
          state_d    = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        // Full drain row before exposure begins
        if (rt.row_tick) begin
          rows_d = rows_nx;
        end
        if (row_done) begin
          rows_d  = '0;
          state_d = ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        if (rt.row_tick) begin
          rows_d = rows_nx;
        end
        if (row_done) begin
          rows_d  = '0;
          move_d  = '0;
          state_d = ST_TRANSFER;
        end
      end
      ST_TRANSFER: begin
        // Charge-move held for its full transfer time
        move_d = move_q + 1'b1;
        if (move_q == CYC_W'(MOVE_LEN - 1)) begin
          move_d     = '0;
          rows_d     = '0;
          rt.restart = 1'b1;
          state_d    = ST_READ_REF;
        end
      end
      ST_READ_REF: begin
        if (rt.row_tick) begin
          rows_d = rows_nx;
        end
        if (row_done) begin
          rows_d  = '0;
          state_d = ST_GAP;
        end
      end
      ST_GAP: begin
        if (rt.row_tick) begin
          rows_d = rows_nx;
        end
        if (row_done) begin
          rows_d  = '0;
          state_d = ST_READ_SIG;
        end
      end
      ST_READ_SIG: begin
        if (rt.row_tick) begin
          rows_d = rows_nx;
        end
        if (row_done) begin
          rows_d = '0;
          if (last_frame) begin
            state_d = ST_IDLE;
          end else begin
            // Zero frame total means run until stopped
            if (frames_q != '0) begin
              frames_d = frames_q - 1'b1;
            end
            state_d = after_frame;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Stop aborts at once; the drain goes high again so no charge is held
    if (acq_stop) begin
      state_d = ST_IDLE;
      rows_d  = '0;
      move_d  = '0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q  <= ST_IDLE;
      mode_q   <= TRIG_INTERNAL;
      rows_q   <= '0;
      move_q   <= '0;
      frames_q <= '0;
    end else begin
      state_q  <= state_d;
      mode_q   <= mode_d;
      rows_q   <= rows_d;
      move_q   <= move_d;
      frames_q <= frames_d;
    end
  end

  // ==========================================================================
  // Registered outputs, decoded from the next state so they align with it
  // ==========================================================================
  logic drain_d;
  logic move_out_d;
  logic expose_d;
  logic ready_d;
  logic ref_d;
  logic sig_d;
  logic busy_d;

  always_comb begin
    // Drain low only while pixels integrate
    // Drain falls exactly as exposure starts
    drain_d    = (state_d != ST_EXPOSE);
    // One global transfer pulse for every pixel
    move_out_d = (state_d == ST_TRANSFER);
    // Exposure flag spans the common exposure period
    expose_d   = (state_d == ST_EXPOSE);
    ready_d    = (state_d == ST_WAIT_TRIG);
    ref_d      = (state_d == ST_READ_REF);
    sig_d      = (state_d == ST_READ_SIG);
    busy_d     = (state_d != ST_IDLE);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      // Safe idle levels out of reset
      pixel_drain_out       <= PIXEL_DRAIN_RST;
      charge_move_out       <= CHARGE_MOVE_RST;
      exposure_active_out   <= EXPOSURE_RST;
      row_n_exposing_out    <= EXPOSURE_RST;
      all_rows_exposing_out <= EXPOSURE_RST;
      any_row_exposing_out  <= EXPOSURE_RST;
      trigger_ready_out     <= 1'b0;
      readout_phase_out     <= 1'b0;
      ref_frame_out         <= 1'b0;
      signal_frame_out      <= 1'b0;
      busy_out              <= 1'b0;
    end else begin
      pixel_drain_out       <= drain_d;
      charge_move_out       <= move_out_d;
      exposure_active_out   <= expose_d;
      row_n_exposing_out    <= expose_d;
      all_rows_exposing_out <= expose_d;
      any_row_exposing_out  <= expose_d;
      // Ready shown only while waiting for a trigger
      trigger_ready_out     <= ready_d;
      readout_phase_out     <= ref_d | sig_d;
      ref_frame_out         <= ref_d;
      signal_frame_out      <= sig_d;
      busy_out              <= busy_d;
    end
  end

endmodule

/* File: inc/gs_seq_pkg.sv */
// Shared constants and types for the global-shutter exposure sequencer
package gs_seq_pkg;

  // ==========================================================================
  // Clock and row timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS      = 50;
  localparam int unsigned ROW_CYCLES         = 2624;
  localparam int unsigned CYC_W              = 12;

  // Charge transfer pulse: a least time, so round up to whole cycles
  localparam int unsigned CHARGE_MOVE_NS     = 5500;
  localparam int unsigned CHARGE_MOVE_CYCLES =
    (CHARGE_MOVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Sequence lengths in rows
  // ==========================================================================
  localparam int unsigned DRAIN_ROWS         = 1;
  localparam int unsigned INTERFRAME_ROWS    = 9;
  localparam int unsigned FULL_FRAME_ROWS    = 1080;
  localparam int unsigned EXP_W              = 21;
  localparam int unsigned ROI_W              = 12;
  localparam int unsigned GAP_W              = 8;
  localparam int unsigned FRAME_CNT_W        = 16;

  // ==========================================================================
  // Reset values of the pin-facing outputs
  // ==========================================================================
  localparam logic        PIXEL_DRAIN_RST    = 1'b1;
  localparam logic        CHARGE_MOVE_RST    = 1'b0;
  localparam logic        EXPOSURE_RST       = 1'b0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    TRIG_INTERNAL,
    TRIG_EXTERNAL,
    TRIG_SOFTWARE
  } trig_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_TRIG,
    ST_DRAIN,
    ST_EXPOSE,
    ST_TRANSFER,
    ST_READ_REF,
    ST_GAP,
    ST_READ_SIG
  } seq_state_t;

endpackage

/* File: inc/row_tick_if.sv */
// Carrier between the sequencer and its row-period timer
interface row_tick_if;
  logic restart;
  logic row_tick;

  modport timer (
    input  restart,
    output row_tick
  );

  modport seq (
    output restart,
    input  row_tick
  );
endinterface

/* File: rtl/row_timer.sv */
// Row-period timer: one-cycle tick at the end of every row
module row_timer
  import gs_seq_pkg::*;
#(
  parameter int unsigned ROW_LEN = ROW_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rstn,
  row_tick_if.timer rt
);

  // ==========================================================================
  // Cycle counter
  // ==========================================================================
  logic [CYC_W-1:0] cnt_q;
  logic [CYC_W-1:0] cnt_d;
  logic             last;

  // Restart wins so a new state always begins on a full row
  always_comb begin
    last        = (cnt_q == CYC_W'(ROW_LEN - 1));
    rt.row_tick = last & ~rt.restart;
    if (rt.restart || last) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

/* File: verif/gs_seq_chk.sv */
// Concurrent checks on the sequencer's pin-facing outputs
module gs_seq_chk
  import gs_seq_pkg::*;
#(
  parameter int unsigned ROW_LEN  = ROW_CYCLES,
  parameter int unsigned MOVE_LEN = CHARGE_MOVE_CYCLES,
  parameter int unsigned MIN_GAP  = INTERFRAME_ROWS
) (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       acq_start,
  input wire logic       acq_stop,
  input wire logic [1:0] trig_mode,
  input wire logic       sw_trig,
  input wire logic       pixel_drain_out,
  input wire logic       charge_move_out,
  input wire logic       exposure_active_out,
  input wire logic       row_n_exposing_out,
  input wire logic       all_rows_exposing_out,
  input wire logic       any_row_exposing_out,
  input wire logic       trigger_ready_out,
  input wire logic       readout_phase_out,
  input wire logic       ref_frame_out,
  input wire logic       signal_frame_out,
  input wire logic       busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mv_cnt_q;
  logic [15:0] gap_cnt_q;

  // ==========================================================================
  // Helper counters
  // ==========================================================================
  // Gap counter restarts on every reference row, so it measures the gap only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mv_cnt_q  <= 16'h0;
      gap_cnt_q <= 16'h0;
    end else begin
      mv_cnt_q  <= charge_move_out ? mv_cnt_q + 16'h1 : 16'h0;
      gap_cnt_q <= ref_frame_out ? 16'h0 : gap_cnt_q + 16'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_move_end;
    $fell(charge_move_out) && !$past(acq_stop);
  endsequence

  // ==========================================================================
  // Assertions
  // ==========================================================================
  chk_row_flags_same: assert property (
    row_n_exposing_out == exposure_active_out
    && all_rows_exposing_out == exposure_active_out
    && any_row_exposing_out == exposure_active_out)
    else $error("row exposure flags differ from exposure active");
  chk_drain_vs_expose: assert property (
    pixel_drain_out != exposure_active_out)
    else $error("drain and exposure active not complementary");
  chk_fall_starts_exp: assert property (
    $fell(pixel_drain_out) |-> exposure_active_out && !charge_move_out)
    else $error("drain fall did not start exposure");
  chk_move_ends_exp: assert property (
    $fell(exposure_active_out) && !$past(acq_stop)
    |-> charge_move_out && pixel_drain_out)
    else $error("exposure end without charge move");
  chk_move_length: assert property (
    s_move_end |-> mv_cnt_q == MOVE_LEN)
    else $error("charge move pulse length wrong");
  chk_ref_after_move: assert property (
    s_move_end |-> ref_frame_out)
    else $error("reference readout did not follow charge move");
  chk_phase_marks: assert property (
    readout_phase_out == (ref_frame_out || signal_frame_out)
    && !(ref_frame_out && signal_frame_out))
    else $error("readout phase does not match frame flags");
  chk_gap_min: assert property (
    $rose(signal_frame_out) |-> gap_cnt_q >= MIN_GAP * ROW_LEN)
    else $error("gap before signal readout too short");
  chk_ready_waits: assert property (
    trigger_ready_out |-> busy_out && pixel_drain_out && !readout_phase_out)
    else $error("trigger ready outside a waiting state");
  chk_sw_take: assert property (
    trigger_ready_out && sw_trig && !acq_stop && trig_mode == 2'h2
    |=> !trigger_ready_out)
    else $error("software trigger not taken");
  chk_start_busy: assert property (
    acq_start && !busy_out && !acq_stop |=> busy_out ##1 busy_out)
    else $error("start did not launch the sequence");
  chk_idle_levels: assert property (
    !busy_out |-> pixel_drain_out && !charge_move_out && !exposure_active_out)
    else $error("idle output levels wrong");
endmodule

bind global_shutter_exposure_sequencer gs_seq_chk #(
  .ROW_LEN (ROW_LEN),
  .MOVE_LEN(MOVE_LEN),
  .MIN_GAP (MIN_GAP)
) u_chk (.mclk, .rstn, .acq_start, .acq_stop, .trig_mode, .sw_trig,
  .pixel_drain_out, .charge_move_out, .exposure_active_out,
  .row_n_exposing_out, .all_rows_exposing_out, .any_row_exposing_out,
  .trigger_ready_out, .readout_phase_out, .ref_frame_out,
  .signal_frame_out, .busy_out);

/* File: verif/trig_partner.sv */
// Trigger equipment model: software pulse and external trigger pin
module trig_partner (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       trigger_ready_out,
  input  wire logic       want_sw,
  input  wire logic       want_ext,
  input  wire logic [3:0] lag,
  output logic            sw_trig,
  output logic            ext_trig_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  logic [2:0] pin_q;
  assign ext_trig_in = (pin_q != 3'h0);

  // ==========================================================================
  // Trigger source
  // ==========================================================================
  // Lag lets the model answer a ready window promptly or late
  // Trigger pulses start only inside ready
  always @(negedge mclk or negedge rstn) begin
    if (!rstn) begin
      wait_q  <= 4'h0;
      pin_q   <= 3'h0;
      sw_trig <= 1'b0;
    end else begin
      wait_q  <= trigger_ready_out ? wait_q + 4'h1 : 4'h0;
      sw_trig <= want_sw && trigger_ready_out && wait_q >= lag && !sw_trig;
      if (pin_q != 3'h0) begin
        pin_q <= pin_q - 3'h1;
      end else if (want_ext && trigger_ready_out && wait_q >= lag) begin
        pin_q <= 3'h4;
      end
    end
  end
endmodule

/* File: verif/global_shutter_exposure_sequencer_tb_top.sv */
// Self-checking bench for the global-shutter exposure sequencer
module global_shutter_exposure_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import gs_seq_pkg::*;
  localparam int R = 8;
  localparam int M = 3;
  localparam int G = 2;
  localparam int E = 3;
  localparam int F = 2;

  logic                   mclk, rstn, acq_start, acq_stop, sw_trig;
  logic                   ext_trig_in, want_sw, want_ext;
  logic [3:0]             lag;
  logic [1:0]             trig_mode;
  logic [EXP_W-1:0]       exposure_rows;
  logic [ROI_W-1:0]       frame_rows;
  logic [GAP_W-1:0]       gap_rows;
  logic [FRAME_CNT_W-1:0] frame_total;
  logic                   drain, move, expo, rown, allr, anyr;
  logic                   ready, phase, refo, sigo, busy;
  int                     n_exp, n_mv, n_ref, n_sig, n_idle;
  int                     n_fail, n_tests, cyc;

  global_shutter_exposure_sequencer #(.ROW_LEN(R), .MOVE_LEN(M),
    .MIN_GAP(G)) dut (.mclk(mclk), .rstn(rstn), .acq_start(acq_start),
    .acq_stop(acq_stop), .trig_mode(trig_mode), .sw_trig(sw_trig),
    .ext_trig_in(ext_trig_in), .exposure_rows(exposure_rows),
    .frame_rows(frame_rows), .gap_rows(gap_rows),
    .frame_total(frame_total), .pixel_drain_out(drain),
    .charge_move_out(move), .exposure_active_out(expo),
    .row_n_exposing_out(rown), .all_rows_exposing_out(allr),
    .any_row_exposing_out(anyr), .trigger_ready_out(ready),
    .readout_phase_out(phase), .ref_frame_out(refo),
    .signal_frame_out(sigo), .busy_out(busy));

  trig_partner partner (.mclk(mclk), .rstn(rstn), .trigger_ready_out(ready),
    .want_sw(want_sw), .want_ext(want_ext), .lag(lag), .sw_trig(sw_trig),
    .ext_trig_in(ext_trig_in));

  // ==========================================================================
  // Clock, phase counters and timeout
  // ==========================================================================
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Waiting time covers drain row plus gap rows, but not trigger waits
  always @(posedge mclk) begin
    cyc    <= cyc + 1;
    n_exp  <= n_exp + int'(expo === 1'b1);
    n_mv   <= n_mv + int'(move === 1'b1);
    n_ref  <= n_ref + int'(refo === 1'b1);
    n_sig  <= n_sig + int'(sigo === 1'b1);
    n_idle <= n_idle + int'((busy && drain && !move && !phase && !ready)
      === 1'b1);
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic clr();
    n_exp = 0; n_mv = 0; n_ref = 0; n_sig = 0; n_idle = 0;
  endtask

  task automatic start(logic [1:0] mode, int frames);
    @(negedge mclk);
    trig_mode   = mode;
    frame_total = FRAME_CNT_W'(frames);
    clr();
    acq_start   = 1'b1;
    @(negedge mclk);
    acq_start   = 1'b0;
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge mclk);
    chk("sequence end", 32'h0, {31'h0, busy});
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    chk("drain at reset", 32'h1, {31'h0, drain});
    chk("idle at reset", 32'h0, {28'h0, expo, move, busy, ready});
  endtask

  // A second start while busy must be ignored
  // Gap below the minimum is stretched to the minimum
  task automatic t_internal(int frames, int gap);
    int g;
    g = (gap > G) ? gap : G;
    gap_rows = GAP_W'(gap);
    start(2'h3, frames);
    repeat (5) @(negedge mclk);
    acq_start = 1'b1;
    @(negedge mclk);
    acq_start = 1'b0;
    wait_idle();
    chk("exposure cycles", frames * E * R, n_exp);
    chk("move cycles", frames * M, n_mv);
    chk("ref cycles", frames * F * R, n_ref);
    chk("sig cycles", frames * F * R, n_sig);
    chk("drain and gap cycles", frames * (R + g * R), n_idle);
  endtask

  // Wrong-kind trigger first, then the right one through the partner
  task automatic t_trig(logic [1:0] mode, logic [3:0] wait_lag);
    lag = wait_lag;
    start(mode, 1);
    want_sw  = (mode == 2'h1);
    want_ext = (mode == 2'h2);
    repeat (20) @(negedge mclk);
    chk("ready holds", 32'h1, {31'h0, ready});
    chk("no early exposure", 32'h0, n_exp);
    want_sw  = (mode == 2'h2);
    want_ext = (mode == 2'h1);
    wait_idle();
    want_sw  = 1'b0;
    want_ext = 1'b0;
    chk("triggered exposure", E * R, n_exp);
    chk("triggered signal", F * R, n_sig);
  endtask

  task automatic t_stop();
    int i;
    start(2'h0, 0);
    for (i = 0; i < 100 && expo !== 1'b1; i++) @(negedge mclk);
    chk("exposure reached", 32'h1, {31'h0, expo});
    acq_stop = 1'b1;
    @(negedge mclk);
    acq_stop = 1'b0;
    chk("stop levels", 32'h2, {29'h0, busy, drain, expo});
  endtask

  task automatic stop_test();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0; acq_start = 1'b0; acq_stop = 1'b0; trig_mode = 2'h0;
    want_sw = 1'b0; want_ext = 1'b0; lag = 4'h0; cyc = 0;
    exposure_rows = EXP_W'(E); frame_rows = ROI_W'(F);
    gap_rows = 8'h0; frame_total = 16'h1; n_fail = 0; n_tests = 0;
    clr();
    repeat (20) @(negedge mclk);
    t_reset();
    rstn = 1'b1;
    t_internal(1, 0);
    t_internal(2, 3);
    t_trig(2'h2, 4'h0);
    t_trig(2'h1, 4'h5);
    t_stop();
    stop_test();
  end
endmodule
